//--- rtl/adp_regs.svh
// Constants of the converter output data port: field positions, reset values, counts.
// Assumes inclusion by bare name from the package and the top module.
//
// How it works
// - A high code select yields straight binary results, a low one twos complement.
// - With clock source select high, serial bits move on the bit clock the host supplies.
// - With clock source select low, each convert command while busy is high sends the previous result on 16 pulses.
// - Byte select low puts result bits 15 to 8 on the parallel pins, bit 15 on the top pin.
// - Byte select high puts result bits 7 to 0 on the parallel pins, bit 0 on the bottom pin.
// - The parallel pins float whenever device select is high or read/convert is low.
// - In internal clock mode exactly 16 bit clock pulses follow each start, then the clock idles low.
// - With device select low and busy high, a falling read/convert edge starts a new conversion.
// - Busy goes low at conversion start and stays low until outputs are updated.
// - In internal clock mode each serial bit is steady across both edges of the bit clock.
`ifndef ADP_REGS_SVH
`define ADP_REGS_SVH

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define ADP_RES_W 16
`define ADP_FIFO_DEPTH 8
`define ADP_SER_PULSES 16
// Four system clocks per bit clock period: low, high, high, low.
`define ADP_PH_PER_BIT 4
`define ADP_SER_LAST 6'h3f
`define ADP_RES_RST 16'h0000
`define ADP_MSB 15

`endif

//--- rtl/adp_pkg.sv
// Types of the converter output data port.
// Assumes adp_regs.svh is on the include path.
`include "adp_regs.svh"

package adp_pkg;

  // --------------------------------------------------------------------------
  // Conversion sequencer states, Gray coded along idle, convert, drain.
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADP_IDLE = 2'b00,
    ADP_CONV = 2'b01,
    ADP_DRAIN = 2'b11
  } adp_state_t;

  // --------------------------------------------------------------------------
  // Host control pins as one group.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic dev_sel_b;
    logic read_conv;
    logic byte_sel;
    logic output_code_select;
    logic serial_clock_source_select;
  } adp_pins_t;

endpackage

//--- rtl/adp_top.sv
// Output data port of a 16-bit sampling converter, with its sample FIFO.
// Assumes the converter core pushes twos complement samples on clk, and that
// the host drives the select pins asynchronously and may supply the bit clock.
`include "adp_regs.svh"

// ----------------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------------
module adp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D - 1)) ? '0 : AW'(wr_r + 1'b1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D - 1)) ? '0 : AW'(rd_r + 1'b1);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Port top
// ----------------------------------------------------------------------------
module adp_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire adp_pkg::adp_pins_t pins,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [15:0] sample_data,
  input wire logic serial_bit_clock_in,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe_b,
  output logic serial_result_out,
  output logic [7:0] par_out,
  output logic [7:0] par_oe_b,
  output logic busy_b
);
  function automatic logic [15:0] adp_encode(input logic [15:0] raw, input logic sb);
    adp_encode = sb ? {~raw[`ADP_MSB], raw[14:0]} : raw;
  endfunction

  adp_pkg::adp_pins_t meta_r;
  adp_pkg::adp_pins_t pin_r;
  adp_pkg::adp_state_t state_r;
  logic sel_prev_r;
  logic start;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic take;
  logic [15:0] res_r;
  logic res_tgl_r;
  logic ser_act_r;
  logic [5:0] ser_cnt_r;
  logic [15:0] ser_sh_r;
  logic sdo_int_r;
  logic bclk_r;
  logic ext_mode_r;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '{dev_sel_b: 1'b1, read_conv: 1'b1, default: 1'b0};
      pin_r <= '{dev_sel_b: 1'b1, read_conv: 1'b1, default: 1'b0};
    end else begin
      meta_r <= pins;
      pin_r <= meta_r;
    end
  end

  // Select and read/convert are ORed, so either falling last makes the start.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_prev_r <= 1'b1;
    end else begin
      sel_prev_r <= pin_r.dev_sel_b | pin_r.read_conv;
    end
  end
  assign start = sel_prev_r && !(pin_r.dev_sel_b | pin_r.read_conv) && (state_r == adp_pkg::ADP_IDLE);

  // --------------------------------------------------------------------------
  // Sample FIFO; it drains only during a conversion, so the core sees stalls.
  // --------------------------------------------------------------------------
  adp_fifo #(.W(`ADP_RES_W), .D(`ADP_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_data)
  );
  assign take = (state_r == adp_pkg::ADP_CONV) && fifo_valid;

  // --------------------------------------------------------------------------
  // Conversion sequencer and busy
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= adp_pkg::ADP_IDLE;
      busy_b <= 1'b1;
    end else begin
      case (state_r)
        adp_pkg::ADP_IDLE: begin
          if (start) begin
            state_r <= adp_pkg::ADP_CONV;
            busy_b <= 1'b0;
          end
        end
        adp_pkg::ADP_CONV: begin
          if (take) begin
            state_r <= adp_pkg::ADP_DRAIN;
          end
        end
        adp_pkg::ADP_DRAIN: begin
          // Busy rises only once the result is stored and the burst has ended.
          if (!ser_act_r) begin
            state_r <= adp_pkg::ADP_IDLE;
            busy_b <= 1'b1;
          end
        end
        default: begin
          state_r <= adp_pkg::ADP_IDLE;
          busy_b <= 1'b1;
        end
      endcase
    end
  end

  // The toggle tells the link side a new word is stable in res_r.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      res_r <= `ADP_RES_RST;
      res_tgl_r <= 1'b0;
    end else if (take) begin
      res_r <= adp_encode(fifo_data, pin_r.output_code_select);
      res_tgl_r <= ~res_tgl_r;
    end
  end

  // --------------------------------------------------------------------------
  // Parallel lane
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      par_out <= 8'h00;
      par_oe_b <= 8'hff;
    end else begin
      par_out <= pin_r.byte_sel ? res_r[7:0] : res_r[15:8];
      par_oe_b <= {8{pin_r.dev_sel_b | !pin_r.read_conv}};
    end
  end

  // --------------------------------------------------------------------------
  // Internal bit clock burst. The pin lags bclk_r by one register, so data
  // moves one cycle after the pin falls, in the middle of its low time, and
  // never together with either edge of the pin.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ser_act_r <= 1'b0;
      ser_cnt_r <= 6'h00;
      ser_sh_r <= 16'h0000;
      sdo_int_r <= 1'b0;
      bclk_r <= 1'b0;
    end else if (start && !pin_r.serial_clock_source_select) begin
      ser_act_r <= 1'b1;
      ser_cnt_r <= 6'h00;
      ser_sh_r <= {res_r[14:0], 1'b0};
      sdo_int_r <= res_r[`ADP_MSB];
      bclk_r <= 1'b0;
    end else if (ser_act_r) begin
      ser_cnt_r <= ser_cnt_r + 6'h01;
      bclk_r <= (ser_cnt_r[1:0] == 2'h0) || (ser_cnt_r[1:0] == 2'h1);
      if ((ser_cnt_r[1:0] == 2'h0) && (ser_cnt_r != 6'h00)) begin
        sdo_int_r <= ser_sh_r[`ADP_MSB];
        ser_sh_r <= {ser_sh_r[14:0], 1'b0};
      end
      if (ser_cnt_r == `ADP_SER_LAST) begin
        ser_act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_mode_r <= 1'b0;
      serial_bit_clock_oe_b <= 1'b1;
      serial_bit_clock_out <= 1'b0;
    end else begin
      ext_mode_r <= pin_r.serial_clock_source_select;
      serial_bit_clock_oe_b <= pin_r.serial_clock_source_select;
      serial_bit_clock_out <= bclk_r;
    end
  end

  // --------------------------------------------------------------------------
  // External bit clock domain. The result word is quasi-static while the
  // toggle crosses, so it is sampled directly once the toggle is seen.
  // The host's clock may stop; a new word loads on its third rising edge after the toggle moves.
  // --------------------------------------------------------------------------
  logic lk_rst_meta_r;
  logic lk_rst_b_r;
  logic lk_tgl_meta_r;
  logic lk_tgl_r;
  logic lk_tgl_seen_r;
  logic [15:0] lk_sh_r;
  logic lk_sdo_r;

  always_ff @(posedge serial_bit_clock_in) begin
    lk_rst_meta_r <= rst_b;
    lk_rst_b_r <= lk_rst_meta_r;
  end

  always_ff @(posedge serial_bit_clock_in) begin
    if (!lk_rst_b_r) begin
      lk_tgl_meta_r <= 1'b0;
      lk_tgl_r <= 1'b0;
      lk_tgl_seen_r <= 1'b0;
      lk_sh_r <= 16'h0000;
      lk_sdo_r <= 1'b0;
    end else begin
      lk_tgl_meta_r <= res_tgl_r;
      lk_tgl_r <= lk_tgl_meta_r;
      lk_tgl_seen_r <= lk_tgl_r;
      if (lk_tgl_r != lk_tgl_seen_r) begin
        lk_sdo_r <= res_r[`ADP_MSB];
        lk_sh_r <= {res_r[14:0], 1'b0};
      end else begin
        lk_sdo_r <= lk_sh_r[`ADP_MSB];
        lk_sh_r <= {lk_sh_r[14:0], 1'b0};
      end
    end
  end

  // The one data pin is shared; the mode picks which domain's flop feeds it.
  assign serial_result_out = ext_mode_r ? lk_sdo_r : sdo_int_r;
endmodule

//--- sim/adp_top_assertions.sv
// Checker of the converter output data port, bound to adp_top.
// Assumes pins reach the outputs through a two-flop sync and one register.
module adp_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire adp_pkg::adp_pins_t pins,
  input wire logic serial_bit_clock_out,
  input wire logic serial_bit_clock_oe_b,
  input wire logic serial_result_out,
  input wire logic [7:0] par_out,
  input wire logic [7:0] par_oe_b,
  input wire logic busy_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire idle_w = pins.dev_sel_b | ~pins.read_conv;
  // Select and read/convert are ORed inside, so a start is a fall of their OR.
  wire cmd_w = pins.dev_sel_b | pins.read_conv;
  wire int_w = ~pins.serial_clock_source_select;
  logic [4:0] pulses_r;
  // Restarted at each conversion, so a short or long burst shows when busy rises.
  always_ff @(posedge clk) begin
    if (!rst_b || $fell(busy_b)) begin
      pulses_r <= 5'h00;
    end else if ($rose(serial_bit_clock_out)) begin
      pulses_r <= pulses_r + 5'h01;
    end
  end
  sequence s_start;
    busy_b && $fell(cmd_w);
  endsequence
  sequence s_quiet;
    (busy_b && $stable(pins))[*5];
  endsequence
  a_par_float: assert property (idle_w[*4] |=> par_oe_b == 8'hff)
    else $error("lane not floating");
  a_par_driven: assert property ((!idle_w)[*4] |=> par_oe_b == 8'h00)
    else $error("lane not driven");
  a_busy_start: assert property (s_start |-> ##[1:5] !busy_b)
    else $error("busy missing");
  a_result_held: assert property (s_quiet |-> $stable(par_out))
    else $error("lane changed while idle");
  a_burst_count: assert property ($rose(busy_b) && int_w |-> pulses_r == 5'h10)
    else $error("pulse count");
  a_clock_rests: assert property ((busy_b && int_w)[*3] |-> !serial_bit_clock_out)
    else $error("bit clock not idle");
  a_bit_steady: assert property ((!serial_bit_clock_oe_b)[*4] ##0 $changed(serial_result_out)
    |-> !serial_bit_clock_out && !$past(serial_bit_clock_out))
    else $error("data moved near edge");
  a_clock_owner: assert property ($stable(pins.serial_clock_source_select)[*5]
    |-> ##1 serial_bit_clock_oe_b == $past(pins.serial_clock_source_select))
    else $error("bit clock owner");
endmodule

bind adp_top adp_checker u_adp_checker (.clk, .rst_b, .pins, .serial_bit_clock_out,
  .serial_bit_clock_oe_b, .serial_result_out, .par_out, .par_oe_b, .busy_b);

//--- sim/adp_host_model.sv
// Host on the serial side: makes the link clock in frames and captures results.
// Assumes the bench calls ext_frame and reads cap and n_edge.
module adp_host_model (
  input wire logic serial_bit_clock_out,
  input wire logic serial_bit_clock_oe_b,
  input wire logic serial_result_out,
  output logic serial_bit_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lck = 1'b0;
  logic run = 1'b0;
  logic [15:0] cap = 16'h0000;
  int n_edge = 0;
  // The link clock rests low between frames; it never runs free.
  always begin
    #6;
    lck = run ? ~lck : 1'b0;
  end
  assign serial_bit_clock_in = serial_bit_clock_oe_b ? lck : serial_bit_clock_out;
  always @(posedge serial_bit_clock_in) begin
    if (!serial_bit_clock_oe_b) begin
      cap = {cap[14:0], serial_result_out};
      n_edge++;
    end
  end
  // Bits are taken on the falling edge, half a period after the device shifts.
  task automatic ext_frame(input int n);
    run = 1'b1;
    repeat (n) @(negedge lck) cap = {cap[14:0], serial_result_out};
    run = 1'b0;
  endtask
endmodule

//--- sim/test_adp_top.sv
// Bench of the output data port: fills the sample buffer, converts in all modes.
// Assumes the design, its checker and the host model are compiled first.
module test_adp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  adp_pkg::adp_pins_t pins = 5'h19;
  logic sample_valid = 1'b0;
  logic [15:0] sample_data = 16'h0000;
  logic sample_ready, serial_bit_clock_in, serial_bit_clock_out, serial_bit_clock_oe_b;
  logic serial_result_out, busy_b;
  logic [7:0] par_out, par_oe_b;
  logic [15:0] q[$];
  logic [15:0] res, prev;
  int n_fail = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  adp_top u_adp_top (.clk, .rst_b, .pins, .sample_valid, .sample_ready, .sample_data,
    .serial_bit_clock_in, .serial_bit_clock_out, .serial_bit_clock_oe_b,
    .serial_result_out, .par_out, .par_oe_b, .busy_b);
  adp_host_model u_adp_host_model (.serial_bit_clock_out, .serial_bit_clock_oe_b,
    .serial_result_out, .serial_bit_clock_in);
  function automatic logic [15:0] exp_code(input logic [15:0] raw, input logic sb);
    return sb ? (raw ^ 16'h8000) : raw;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(18597));
    // Link flops reset on their own clock, so it runs once clk has set the pin owner.
    cyc(2);
    u_adp_host_model.ext_frame(5);
    cyc(6);
    rst_b = 1'b1;
    check("lane", 16'h00ff, 16'(par_oe_b));
    q = {16'h8000, 16'h7fff};
    repeat (6) q.push_back(16'($urandom()));
    sample_valid = 1'b1;
    foreach (q[i]) begin
      sample_data = q[i];
      cyc(1);
    end
    sample_valid = 1'b0;
    check("full", 16'h0000, 16'(sample_ready));
    prev = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      pins.output_code_select = i[0];
      pins.serial_clock_source_select = i[1];
      cyc(4);
      pins.dev_sel_b = 1'b0;
      pins.read_conv = 1'b0;
      cyc(5);
      check("lane", 16'h00ff, 16'(par_oe_b));
      pins.read_conv = 1'b1;
      // A second command in mid-burst must not take a sample.
      if (!i[1]) begin
        cyc(8);
        pins.read_conv = 1'b0;
        cyc(5);
        pins.read_conv = 1'b1;
      end
      for (int k = 0; k < 200 && busy_b !== 1'b1; k++) cyc(1);
      check("busy", 16'h0001, 16'(busy_b));
      res = exp_code(q.pop_front(), i[0]);
      pins.byte_sel = 1'b0;
      cyc(4);
      check("lane", 16'h0000, 16'(par_oe_b));
      check("high byte", 16'(res[15:8]), 16'(par_out));
      pins.byte_sel = 1'b1;
      cyc(4);
      check("low byte", 16'(res[7:0]), 16'(par_out));
      if (i[1]) begin
        u_adp_host_model.ext_frame(18);
        check("serial", res, u_adp_host_model.cap);
      end else begin
        check("pulses", 16'h0010, 16'(u_adp_host_model.n_edge));
        check("serial", prev, u_adp_host_model.cap);
      end
      u_adp_host_model.n_edge = 0;
      prev = res;
      cyc(1);
    end
    check("drained", 16'h0001, 16'(sample_ready));
    pins.dev_sel_b = 1'b1;
    cyc(4);
    check("lane", 16'h00ff, 16'(par_oe_b));
    end_of_test();
  end
endmodule
